// File: rtl/bit_branch_pkg.sv
// Types shared by the branch and bit-operation execute block
package bit_branch_pkg;
	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} phase_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] data;
		logic rd;
		logic wr;
	} file_req_t;
endpackage

// File: rtl/bit_branch_regs.svh
// Constants for the branch and bit-operation execute block
`ifndef BIT_BRANCH_REGS_SVH
`define BIT_BRANCH_REGS_SVH
`define OPC_RELATIVE_JUMP 4'hD
`define OPC_FILE_BIT_SET 4'h8
`define OPC_TEST_SKIP_CLEAR 4'hB
`define OPC_TEST_SKIP_SET 4'hA
`define IDX_LIMIT 8'h5F
`define PC_RESET 21'h000000
`define BANK_RESET 4'h0
`endif

// File: rtl/branch_and_bit_op_exec.sv
// Execute logic for relative jump, bit set and bit test-skip instructions
// Overview of operation
// - Jump loads PC plus two plus 2n
// - Jump takes two cycles, second is no-op
// - Bit set forces selected bit to one
// - Access flag picks access bank or bank register
// - Extended mode, a=0, f<=95 uses indexed offset
// - Test clear skips next when bit zero
`include "bit_branch_regs.svh"
module branch_and_bit_op_exec (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	input wire logic [3:0] bank_select_reg,
	input wire logic ext_set_en,
	input wire logic [11:0] index_base,
	input wire logic [7:0] file_rdata,
	output bit_branch_pkg::file_req_t file_req,
	output bit_branch_pkg::phase_t phase,
	output logic [20:0] pc,
	output logic flush_fetch,
	output logic forced_nop
);
	import bit_branch_pkg::*;

	phase_t phase_r, phase_nxt;
	logic [20:0] pc_r, pc_nxt;
	logic [15:0] ir_r, ir_nxt;
	logic nop_r, nop_nxt;
	logic [7:0] data_r, data_nxt;
	file_req_t req_r, req_nxt;
	logic flush_r, flush_nxt;

	// Decode of the instruction in execution
	logic [11:0] eff_addr;
	logic [3:0] opc;
	logic [2:0] bit_idx;
	logic [20:0] offset_ext;
	logic [7:0] bit_mask;
	logic bit_val;
	logic live;
	logic is_jump;
	logic is_set;
	logic is_skip_clear;
	logic is_skip_set;
	logic is_bit_op;
	logic jump_flush;

	assign opc = ir_r[15:12];
	assign bit_idx = ir_r[11:9];
	// The offset counts words, so it is doubled into a byte distance
	assign offset_ext = {{9{ir_r[10]}}, ir_r[10:0], 1'b0};
	assign bit_mask = 8'h01 << bit_idx;
	assign bit_val = data_r[bit_idx];

	// A discarded word keeps its opcode bits, so every decode is gated by live
	assign live = !nop_r;
	assign is_jump = live && (opc == `OPC_RELATIVE_JUMP);
	assign is_set = live && (opc == `OPC_FILE_BIT_SET);
	assign is_skip_clear = live && (opc == `OPC_TEST_SKIP_CLEAR);
	assign is_skip_set = live && (opc == `OPC_TEST_SKIP_SET);
	assign is_bit_op = is_set || is_skip_clear || is_skip_set;
	// Unknown opcodes touch nothing: no file access, no flush
	// A jump has loaded its target already, so the next latch must not step past it
	assign jump_flush = flush_r && is_jump;

	data_addr_former u_addr (
		.access_sel(ir_r[8]),
		.file_field(ir_r[7:0]),
		.bank_select_reg(bank_select_reg),
		.ext_set_en(ext_set_en),
		.index_base(index_base),
		.data_addr(eff_addr)
	);

	// Quarter-phase sequencer
	always_comb begin
		case (phase_r)
			PH_Q1: begin
				phase_nxt = PH_Q2;
			end
			PH_Q2: begin
				phase_nxt = PH_Q3;
			end
			PH_Q3: begin
				phase_nxt = PH_Q4;
			end
			PH_Q4: begin
				phase_nxt = PH_Q1;
			end
			default: begin
				phase_nxt = PH_Q1;
			end
		endcase
	end

	// Reset parks the sequencer in Q4 so the first word is latched at the first edge
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase_r <= PH_Q4;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// Instruction latch at the end of Q4
	always_comb begin
		ir_nxt = ir_r;
		nop_nxt = nop_r;
		if (phase_r == PH_Q4) begin
			// A flushed or missing word still occupies a cycle, as a no-op
			ir_nxt = instr_valid ? instr_word : 16'h0000;
			nop_nxt = flush_r || !instr_valid;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ir_r <= 16'h0000;
			nop_r <= 1'b1;
		end else begin
			ir_r <= ir_nxt;
			nop_r <= nop_nxt;
		end
	end

	// Program counter: points at the word being fetched in this cycle
	always_comb begin
		pc_nxt = pc_r;
		if (phase_r == PH_Q4) begin
			// A skipped word is still stepped over; only a jump keeps its target
			if (!jump_flush) begin
				pc_nxt = pc_r + 21'h000002;
			end
		end else if (phase_r == PH_Q3 && is_jump) begin
			// pc_r already holds the incremented address here
			pc_nxt = pc_r + offset_ext;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pc_r <= `PC_RESET;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	// Operand copy: captured at the end of Q2, modified in Q3
	always_comb begin
		data_nxt = data_r;
		if (phase_r == PH_Q2 && req_r.rd) begin
			data_nxt = file_rdata;
		end else if (phase_r == PH_Q3 && is_set) begin
			data_nxt = data_r | bit_mask;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			data_r <= 8'h00;
		end else begin
			data_r <= data_nxt;
		end
	end

	// Strobes are registered one phase ahead, so each stands for exactly its phase
	always_comb begin
		req_nxt = '0;
		req_nxt.addr = req_r.addr;
		if (phase_r == PH_Q1 && is_bit_op) begin
			req_nxt.addr = eff_addr;
			req_nxt.rd = 1'b1;
		end else if (phase_r == PH_Q3 && is_set) begin
			req_nxt.data = data_r | bit_mask;
			req_nxt.wr = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			req_r <= '0;
		end else begin
			req_r <= req_nxt;
		end
	end

	// Decided in Q3 so the fetch stage sees the discard for the whole of Q4
	always_comb begin
		flush_nxt = 1'b0;
		if (phase_r == PH_Q3) begin
			if (is_jump) begin
				flush_nxt = 1'b1;
			end else if (is_skip_clear) begin
				flush_nxt = !bit_val;
			end else if (is_skip_set) begin
				flush_nxt = bit_val;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flush_r <= 1'b0;
		end else begin
			flush_r <= flush_nxt;
		end
	end

	// Every output comes straight from a flop
	assign file_req = req_r;
	assign phase = phase_r;
	assign pc = pc_r;
	assign flush_fetch = flush_r;
	assign forced_nop = nop_r;
endmodule

// File: rtl/data_addr_former.sv
// Data address formation for file-register operands
`include "bit_branch_regs.svh"
module data_addr_former (
	input wire logic access_sel,
	input wire logic [7:0] file_field,
	input wire logic [3:0] bank_select_reg,
	input wire logic ext_set_en,
	input wire logic [11:0] index_base,
	output logic [11:0] data_addr
);
	always_comb begin
		if (access_sel) begin
			data_addr = {bank_select_reg, file_field};
		end else if (ext_set_en && (file_field <= `IDX_LIMIT)) begin
			data_addr = index_base + {4'h0, file_field};
		end else if (file_field[7]) begin
			data_addr = {4'hF, file_field};
		end else begin
			data_addr = {4'h0, file_field};
		end
	end
endmodule

// File: tb/exec_sva.sv
// Port assertions for the execute block
module exec_sva
	import bit_branch_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	input wire file_req_t file_req,
	input wire logic [7:0] file_rdata,
	input wire phase_t phase,
	input wire logic [20:0] pc,
	input wire logic flush_fetch,
	input wire logic forced_nop
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire [20:0] tgt = pc + 21'h2 + {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
	AST_RD: assert property (file_req.rd |-> phase == PH_Q2) else $error("rd");
	AST_WR: assert property (file_req.wr |-> phase == PH_Q4) else $error("wr");
	AST_SEQ: assert property (phase == PH_Q1 |=> phase == PH_Q2 ##1 phase == PH_Q3)
		else $error("seq");
	AST_SET: assert property (file_req.wr |-> file_req.data ==
		($past(file_rdata, 2) | (8'h01 << $past(instr_word[11:9], 4)))) else $error("set");
	AST_JMP: assert property (phase == PH_Q4 && instr_valid && !flush_fetch &&
		instr_word[15:12] == 4'hD |-> ##4 flush_fetch && pc == $past(tgt, 4)) else $error("jump");
	AST_NOP: assert property (flush_fetch |=> forced_nop [*4]) else $error("nop");
	AST_NOWR: assert property (forced_nop |-> !file_req.wr) else $error("nop wr");
	AST_PC: assert property (phase == PH_Q3 |-> $stable(pc)) else $error("pc");
endmodule
bind branch_and_bit_op_exec exec_sva sva_i (.*);

// File: tb/file_model.sv
// Data register file model for the execute block
module file_model
	import bit_branch_pkg::*;
(
	input wire logic ref_clk,
	input wire file_req_t file_req,
	output logic [7:0] file_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [4096];
	logic [7:0] junk = 8'h5A;
	initial foreach (mem[n]) mem[n] = 8'(n * 59);
	// Toggles outside reads so a mistimed sample cannot match by luck
	assign file_rdata = file_req.rd ? mem[file_req.addr] : junk;
	always @(posedge ref_clk) begin
		junk <= ~junk;
		if (file_req.wr) mem[file_req.addr] <= file_req.data;
	end
endmodule

// File: tb/test_branch_and_bit_op_exec.sv
// Self-checking bench for the execute block
module test_branch_and_bit_op_exec;
	import bit_branch_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// The cycle seen at reset release is a no-op, so the model starts flushed
	logic ref_clk = 0, reset = 1, instr_valid = 1, ext_set_en = 0, sk = 0, nf = 1;
	logic [15:0] instr_word = 0, i;
	logic [3:0] bank_select_reg = 0, ops [4] = '{4'hD, 4'h8, 4'hB, 4'hA};
	logic [11:0] index_base = 0, ad;
	logic [7:0] file_rdata;
	logic [20:0] pc, pm = 0;
	file_req_t file_req;
	phase_t phase;
	logic flush_fetch, forced_nop;
	int num_errors = 0, checks_done = 0;
	branch_and_bit_op_exec dut (.*);
	file_model fm (.*);
	initial forever #50 ref_clk = ~ref_clk;
	task chk(input logic [20:0] a, e);
		checks_done++;
		if (a !== e) begin
			num_errors++;
			$display("Error %0t: %h vs %h", $time, a, e);
		end
	endtask
	task summarize;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h538409C9));
		repeat (12) @(negedge ref_clk);
		reset = 0;
		repeat (300) begin
			i = instr_word;
			ad = i[8] ? {bank_select_reg, i[7:0]} : (ext_set_en && i[7:0] <= 8'h5F) ?
				index_base + i[7:0] : {{4{i[7]}}, i[7:0]};
			sk = !nf && i[15:12] == 4'hD;
			if (sk)
				pm = pm + {{9{i[10]}}, i[10:0], 1'b0};
			if (!nf && i[15:13] == 3'h5)
				sk = fm.mem[ad][i[11:9]] ^ i[12];
			chk(pc, pm);
			chk(flush_fetch, sk);
			chk(forced_nop, nf);
			chk(file_req.wr, !nf && i[15:12] == 4'h8);
			if (!nf && i[15:12] == 4'h8)
				chk({file_req.addr, file_req.data}, {ad, fm.mem[ad] | 8'h1 << i[11:9]});
			nf = sk;
			instr_word = {ops[$urandom % 4], 12'($urandom)};
			{ext_set_en, bank_select_reg, index_base} = 17'($urandom);
			// A jump holds its target through the flushed cycle; a skip steps past the word
			pm = pm + ((sk && i[15:12] == 4'hD) ? 21'h0 : 21'h2);
			repeat (4) @(negedge ref_clk);
		end
		summarize;
	end
endmodule
